// File: pkg/ccr_pkg.sv
package ccr_pkg;
	// ================================================================
	// Register map
	localparam logic [7:0] CCR_FCC_ADDR   = 8'h02;
	localparam logic [7:0] CCR_PTC_ADDR   = 8'h03;
	localparam logic [7:0] CCR_CVC_ADDR   = 8'h04;
	localparam logic [7:0] CCR_TTC_ADDR   = 8'h05;
	localparam int         CCR_NREG       = 4;
	localparam logic [7:0] CCR_FCC_RESET  = 8'h60;
	localparam logic [7:0] CCR_PTC_RESET  = 8'h11;
	localparam logic [7:0] CCR_CVC_RESET  = 8'hB2;
	localparam logic [7:0] CCR_TTC_RESET  = 8'h9A;
	localparam logic [7:0] CCR_UNMAPPED   = 8'h00;
	// ================================================================
	// Field positions
	localparam int CCR_CODE6_LSB    = 2;
	localparam int CCR_REDUCED_BIT  = 0;
	localparam int CCR_HI4_LSB      = 4;
	localparam int CCR_ENTRY_BIT    = 1;
	localparam int CCR_RECHG_BIT    = 0;
	localparam int CCR_TERM_EN_BIT  = 7;
	localparam int CCR_TERM_IND_BIT = 6;
	localparam int CCR_WDOG_LSB     = 4;
	localparam int CCR_TIMER_EN_BIT = 3;
	localparam int CCR_TLIM_LSB     = 1;
	localparam int CCR_COLD_BIT     = 0;
	// ================================================================
	// Code weights, offsets and decode values
	localparam logic [12:0] CCR_FAST_STEP_MA = 13'h0040;
	localparam logic [12:0] CCR_FAST_BASE_MA = 13'h0200;
	localparam logic [12:0] CCR_IPRE_STEP_MA = 13'h0080;
	localparam logic [12:0] CCR_IPRE_BASE_MA = 13'h0080;
	localparam logic [12:0] CCR_VOLT_STEP_MV = 13'h0010;
	localparam logic [12:0] CCR_VOLT_BASE_MV = 13'h0DB0;
	localparam logic [5:0]  CCR_VOLT_MAX     = 6'h38;
	localparam logic [12:0] CCR_FIFTH_DIV    = 13'h0005;
	localparam logic [11:0] CCR_ENTRY_LO_MV  = 12'hAF0;
	localparam logic [11:0] CCR_ENTRY_HI_MV  = 12'hBB8;
	localparam logic [8:0]  CCR_RECHG_LO_MV  = 9'h064;
	localparam logic [8:0]  CCR_RECHG_HI_MV  = 9'h12C;
	localparam logic [7:0]  CCR_WDOG_OFF_S   = 8'h00;
	localparam logic [7:0]  CCR_WDOG_40_S    = 8'h28;
	localparam logic [7:0]  CCR_WDOG_80_S    = 8'h50;
	localparam logic [7:0]  CCR_WDOG_160_S   = 8'hA0;
	localparam logic [4:0]  CCR_TLIM_5_H     = 5'h05;
	localparam logic [4:0]  CCR_TLIM_8_H     = 5'h08;
	localparam logic [4:0]  CCR_TLIM_12_H    = 5'h0C;
	localparam logic [4:0]  CCR_TLIM_20_H    = 5'h14;
	// ================================================================
	// Carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ccr_req_t;
	typedef struct packed {
		logic [12:0] fast_charge_ma;
		logic [12:0] applied_charge_ma;
		logic [12:0] precharge_ma;
		logic [12:0] termination_ma;
		logic [12:0] charge_voltage_mv;
		logic        voltage_code_valid;
		logic [11:0] entry_threshold_mv;
		logic [8:0]  recharge_offset_mv;
		logic        term_enable;
		logic        term_indicator_early;
		logic [7:0]  watchdog_period_s;
		logic        safety_timer_enable;
		logic [4:0]  time_limit_h;
		logic [12:0] cold_charge_ma;
	} ccr_cfg_t;
	// ================================================================
	// Shared arithmetic and decode
	function automatic logic [12:0] ccr_scale(input logic [5:0] code,
		input logic [12:0] step, input logic [12:0] base);
		ccr_scale = base + ({7'h00, code} * step);
	endfunction
	function automatic logic [12:0] ccr_fifth(input logic [12:0] ma);
		ccr_fifth = ma / CCR_FIFTH_DIV;
	endfunction
	function automatic logic ccr_hit(input logic [7:0] addr);
		ccr_hit = (addr >= CCR_FCC_ADDR) && (addr <= CCR_TTC_ADDR);
	endfunction
	function automatic logic [1:0] ccr_index(input logic [7:0] addr);
		logic [7:0] off;
		off = addr - CCR_FCC_ADDR;
		ccr_index = off[1:0];
	endfunction
endpackage

// File: core/ccr_reg8.sv
module ccr_reg8 #(
	parameter logic [7:0] RESET_VALUE = 8'h00
) (
	// Clock and reset
	input  logic       clk_i,
	input  logic       rst_n_i,
	// Write port
	input  logic       wr_en_i,
	input  logic [7:0] wdata_i,
	// Stored value
	output logic [7:0] q_o
);
	logic [7:0] next_q;

	// Every bit is stored as written, reserved bit included
	always_comb begin
		next_q = wr_en_i ? wdata_i : q_o;
	end

	// Reset to the documented default
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_o <= RESET_VALUE;
		end else begin
			q_o <= next_q;
		end
	end
endmodule

// File: core/ccr_decode.sv
module ccr_decode
	import ccr_pkg::*;
(
	// Raw register contents
	input  logic [7:0] fcc_i,
	input  logic [7:0] ptc_i,
	input  logic [7:0] cvc_i,
	input  logic [7:0] ttc_i,
	// Decoded settings
	output ccr_cfg_t   cfg_o
);
	logic [1:0] wdog;
	logic [1:0] tlim;

	// Field slices
	assign wdog = ttc_i[CCR_WDOG_LSB +: 2];
	assign tlim = ttc_i[CCR_TLIM_LSB +: 2];

	// Turn codes into physical units for the analog loops
	always_comb begin
		cfg_o = '0;
		cfg_o.fast_charge_ma = ccr_scale(fcc_i[CCR_CODE6_LSB +: 6],
			CCR_FAST_STEP_MA, CCR_FAST_BASE_MA);
		cfg_o.applied_charge_ma = fcc_i[CCR_REDUCED_BIT] ?
			ccr_fifth(cfg_o.fast_charge_ma) : cfg_o.fast_charge_ma;
		cfg_o.precharge_ma = ccr_scale({2'h0, ptc_i[CCR_HI4_LSB +: 4]},
			CCR_IPRE_STEP_MA, CCR_IPRE_BASE_MA);
		cfg_o.termination_ma = ccr_scale({2'h0, ptc_i[3:0]},
			CCR_IPRE_STEP_MA, CCR_IPRE_BASE_MA);
		cfg_o.charge_voltage_mv = ccr_scale(cvc_i[CCR_CODE6_LSB +: 6],
			CCR_VOLT_STEP_MV, CCR_VOLT_BASE_MV);
		// Codes above the top setting are flagged, not clamped
		cfg_o.voltage_code_valid = cvc_i[CCR_CODE6_LSB +: 6] <= CCR_VOLT_MAX;
		cfg_o.entry_threshold_mv = cvc_i[CCR_ENTRY_BIT] ?
			CCR_ENTRY_HI_MV : CCR_ENTRY_LO_MV;
		cfg_o.recharge_offset_mv = cvc_i[CCR_RECHG_BIT] ?
			CCR_RECHG_HI_MV : CCR_RECHG_LO_MV;
		cfg_o.term_enable = ttc_i[CCR_TERM_EN_BIT];
		cfg_o.term_indicator_early = ttc_i[CCR_TERM_IND_BIT];
		cfg_o.safety_timer_enable = ttc_i[CCR_TIMER_EN_BIT];
		case (wdog)
			2'h0: cfg_o.watchdog_period_s = CCR_WDOG_OFF_S;
			2'h1: cfg_o.watchdog_period_s = CCR_WDOG_40_S;
			2'h2: cfg_o.watchdog_period_s = CCR_WDOG_80_S;
			default: cfg_o.watchdog_period_s = CCR_WDOG_160_S;
		endcase
		case (tlim)
			2'h0: cfg_o.time_limit_h = CCR_TLIM_5_H;
			2'h1: cfg_o.time_limit_h = CCR_TLIM_8_H;
			2'h2: cfg_o.time_limit_h = CCR_TLIM_12_H;
			default: cfg_o.time_limit_h = CCR_TLIM_20_H;
		endcase
		// Cold band scales the programmed code, not the reduced value
		cfg_o.cold_charge_ma = ttc_i[CCR_COLD_BIT] ?
			ccr_fifth(cfg_o.fast_charge_ma) :
			{1'b0, cfg_o.fast_charge_ma[12:1]};
	end
endmodule

// File: core/ccr_top.sv
// Behaviour
// - Fast-charge current register resets to 0x60, code 011000, 2048 mA.
// - Fast-charge code bits 7:2 give 512 mA plus 64 mA per step.
// - Bit 0 set applies one fifth of the programmed current.
// - Precharge/termination register resets to 0x11, both codes 256 mA.
// - Precharge code bits 7:4 give 128 mA plus 128 mA per step.
// - Termination code bits 3:0 give 128 mA plus 128 mA per step.
// - Charge voltage register resets to 0xB2, 4.208 V.
// - Voltage code bits 7:2 give 3.504 V plus 16 mV per step.
// - Bit 1 picks fast-charge entry threshold: 2.8 V or 3.0 V.
// - Bit 0 picks recharge offset: 100 mV or 300 mV.
// - Termination/timer register resets to 0x9A.
// - All bits read back as last written or reset value.
// - Watchdog field: off, 40 s, 80 s, 160 s.
// - Time limit field: 5, 8, 12, 20 hours.
// - Bit 7 enables termination, bit 3 enables safety timer.
module ccr_top (
	// Clock and reset
	input  logic              CLK_SYS_I,
	input  logic              RST_N_I,
	// Register port from the serial control engine
	input  ccr_pkg::ccr_req_t REG_REQ_I,
	output logic [7:0]        REG_RDATA_O,
	output logic              REG_RVALID_O,
	// Decoded settings to the charge loops
	output ccr_pkg::ccr_cfg_t CFG_O
);
	import ccr_pkg::*;

	// ================================================================
	// Reset release
	logic rst_meta_n;
	logic rst_sync_n;

	// Assert at once, release after two edges to avoid metastable release
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ================================================================
	// Register file
	localparam logic [7:0] CCR_RESETS [CCR_NREG] = '{
		CCR_FCC_RESET, CCR_PTC_RESET, CCR_CVC_RESET, CCR_TTC_RESET
	};

	logic                      req_hit;
	logic [1:0]                req_idx;
	logic [CCR_NREG-1:0]       wr_en;
	logic [CCR_NREG-1:0][7:0]  reg_q;

	// Address decode shared by write and read
	assign req_hit = ccr_hit(REG_REQ_I.addr);
	assign req_idx = ccr_index(REG_REQ_I.addr);

	// One write strobe per register; unmapped writes are dropped
	always_comb begin
		wr_en = '0;
		if (REG_REQ_I.wr && req_hit) begin
			wr_en[req_idx] = 1'b1;
		end
	end

	// Storage cells with their power-on defaults
	genvar gi;
	generate
		for (gi = 0; gi < CCR_NREG; gi++) begin : g_reg
			ccr_reg8 #(
				.RESET_VALUE (CCR_RESETS[gi])
			) u_reg (
				.clk_i   (CLK_SYS_I),
				.rst_n_i (rst_sync_n),
				.wr_en_i (wr_en[gi]),
				.wdata_i (REG_REQ_I.wdata),
				.q_o     (reg_q[gi])
			);
		end
	endgenerate

	// ================================================================
	// Read path
	logic [7:0] next_rdata;
	logic       next_rvalid;

	// Read sees the value before a same-cycle write lands
	always_comb begin
		next_rdata  = REG_RDATA_O;
		next_rvalid = REG_REQ_I.rd;
		if (REG_REQ_I.rd) begin
			next_rdata = req_hit ? reg_q[req_idx] : CCR_UNMAPPED;
		end
	end

	// Data holds until the next read; valid is a pulse
	always_ff @(posedge CLK_SYS_I or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			REG_RDATA_O  <= CCR_UNMAPPED;
			REG_RVALID_O <= 1'b0;
		end else begin
			REG_RDATA_O  <= next_rdata;
			REG_RVALID_O <= next_rvalid;
		end
	end

	// ================================================================
	// Decoded settings
	ccr_cfg_t next_cfg;

	// Reserved bit is kept for readback only and steers nothing
	ccr_decode u_decode (
		.fcc_i (reg_q[0]),
		.ptc_i (reg_q[1]),
		.cvc_i (reg_q[2]),
		.ttc_i (reg_q[3]),
		.cfg_o (next_cfg)
	);

	// Registered so the loops see glitch-free settings
	always_ff @(posedge CLK_SYS_I or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			CFG_O <= '0;
		end else begin
			CFG_O <= next_cfg;
		end
	end

	// ================================================================
	// Checks
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!rst_sync_n);

	// Building blocks for the multi-step checks
	sequence s_release;
		$rose(rst_sync_n);
	endsequence

	sequence s_write_hit;
		REG_REQ_I.wr && req_hit;
	endsequence

	sequence s_read_same;
		REG_REQ_I.rd && !REG_REQ_I.wr && (REG_REQ_I.addr == $past(REG_REQ_I.addr));
	endsequence

	// Register defaults at the first sampled edge after release
	AST_RST_FCC: assert property (s_release |-> reg_q[0] == CCR_FCC_RESET)
		else $error("fast-charge current register reset value wrong");

	AST_RST_PTC: assert property (s_release |-> reg_q[1] == CCR_PTC_RESET)
		else $error("precharge/termination register reset value wrong");

	AST_RST_CVC: assert property (s_release |-> reg_q[2] == CCR_CVC_RESET)
		else $error("charge voltage register reset value wrong");

	AST_RST_TTC: assert property (s_release |-> reg_q[3] == CCR_TTC_RESET)
		else $error("termination/timer register reset value wrong");

	// Readback and unmapped reads
	AST_READBACK: assert property (
		s_write_hit ##1 s_read_same |=> REG_RDATA_O == $past(REG_REQ_I.wdata, 2))
		else $error("readback differs from last write");

	AST_UNMAPPED: assert property (REG_REQ_I.rd && !req_hit |=>
		REG_RVALID_O && REG_RDATA_O == CCR_UNMAPPED)
		else $error("unmapped read not zero");

	// ================================================================
	// Checks on the decode of every field except the early termination indicator

	// Each field against its own weights, one edge behind the register
	AST_FAST_CURRENT: assert property (1'b1 |=> CFG_O.fast_charge_ma ==
		CCR_FAST_BASE_MA + {7'h00, $past(reg_q[0][7:2])} * CCR_FAST_STEP_MA)
		else $error("fast-charge current decode wrong");

	AST_REDUCED: assert property ($past(reg_q[0][0]) |->
		CFG_O.applied_charge_ma * 13'h0005 <= CFG_O.fast_charge_ma &&
		CFG_O.fast_charge_ma - CFG_O.applied_charge_ma * 13'h0005 < 13'h0005)
		else $error("reduced current not one fifth");

	AST_FULL: assert property (!$past(reg_q[0][0]) |->
		CFG_O.applied_charge_ma == CFG_O.fast_charge_ma)
		else $error("applied current differs with reduction off");

	AST_PRE_TERM: assert property (1'b1 |=>
		CFG_O.precharge_ma == 13'h0080 + {9'h000, $past(reg_q[1][7:4])} * 13'h0080 &&
		CFG_O.termination_ma == 13'h0080 + {9'h000, $past(reg_q[1][3:0])} * 13'h0080)
		else $error("precharge or termination current decode wrong");

	AST_VOLTAGE: assert property (1'b1 |=>
		CFG_O.charge_voltage_mv == 13'h0DB0 + {7'h00, $past(reg_q[2][7:2])} * 13'h0010 &&
		CFG_O.voltage_code_valid == ($past(reg_q[2][7:2]) <= 6'h38))
		else $error("charge voltage decode wrong");

	AST_THRESH: assert property (1'b1 |=>
		CFG_O.entry_threshold_mv == ($past(reg_q[2][1]) ? 12'hBB8 : 12'hAF0) &&
		CFG_O.recharge_offset_mv == ($past(reg_q[2][0]) ? 9'h12C : 9'h064))
		else $error("threshold select decode wrong");

	// Sampled one edge ahead, so the all-zero settings just after release are not judged
	AST_WDOG: assert property (reg_q[3][5:4] != 2'h0 |=>
		CFG_O.watchdog_period_s == (8'h28 << ($past(reg_q[3][5:4]) - 2'h1)))
		else $error("watchdog period decode wrong");

	AST_WDOG_OFF: assert property (reg_q[3][5:4] == 2'h0 |=>
		CFG_O.watchdog_period_s == 8'h00)
		else $error("watchdog not disabled for code zero");

	AST_TLIM: assert property (1'b1 |=>
		($past(reg_q[3][2:1]) == 2'h0) == (CFG_O.time_limit_h == 5'h05) &&
		($past(reg_q[3][2:1]) == 2'h3) == (CFG_O.time_limit_h == 5'h14) &&
		($past(reg_q[3][2:1]) == 2'h2) == (CFG_O.time_limit_h == 5'h0C))
		else $error("time limit decode wrong");

	AST_COLD: assert property (1'b1 |=> CFG_O.cold_charge_ma ==
		($past(reg_q[3][0]) ? CFG_O.fast_charge_ma / 13'h0005 : CFG_O.fast_charge_ma >> 1))
		else $error("cold band current wrong");

	AST_ENABLES: assert property (s_write_hit ##1 1'b1 ##1 1'b1 |->
		CFG_O.term_enable == $past(reg_q[3][7]) &&
		CFG_O.safety_timer_enable == $past(reg_q[3][3]))
		else $error("enable bits not following register");

	AST_TLIM_8: assert property (reg_q[3][2:1] == 2'h1 |=>
		CFG_O.time_limit_h == 5'h08)
		else $error("time limit code one wrong");

	// Read valid is a single-cycle answer
	AST_RVALID: assert property (REG_REQ_I.rd |=> REG_RVALID_O ##1
		(REG_RVALID_O == $past(REG_REQ_I.rd)))
		else $error("read valid not a one-cycle answer");

	// ================================================================
	// Checks on reset, writes and the read port

	// Reset keeps every output quiet; the default disable is lifted on purpose
	AST_RESET_QUIET: assert property (@(posedge CLK_SYS_I) disable iff (1'b0)
		!rst_sync_n |->
		!REG_RVALID_O && REG_RDATA_O == CCR_UNMAPPED && CFG_O == '0)
		else $error("outputs not quiet during reset");

	// Settings show the decoded defaults one edge after release
	AST_DEFAULTS: assert property (s_release |=>
		CFG_O.fast_charge_ma == 13'h0800 && CFG_O.applied_charge_ma == 13'h0800 &&
		CFG_O.precharge_ma == 13'h0100 && CFG_O.termination_ma == 13'h0100 &&
		CFG_O.charge_voltage_mv == 13'h1070 && CFG_O.entry_threshold_mv == 12'hBB8 &&
		CFG_O.recharge_offset_mv == 9'h064 && CFG_O.term_enable &&
		!CFG_O.term_indicator_early && CFG_O.safety_timer_enable &&
		CFG_O.watchdog_period_s == 8'h28 && CFG_O.time_limit_h == 5'h08 &&
		CFG_O.cold_charge_ma == 13'h0400)
		else $error("decoded defaults wrong after reset");

	// A mapped write lands at its own edge
	AST_WRITE_LANDS: assert property (s_write_hit |=>
		reg_q[$past(req_idx)] == $past(REG_REQ_I.wdata))
		else $error("write did not land in the addressed register");

	// Without a mapped write nothing moves, unmapped writes included
	AST_HOLD: assert property (!(REG_REQ_I.wr && req_hit) |=> $stable(reg_q))
		else $error("register changed without a write");

	// A mapped read returns what the register held at the read edge
	AST_READ_MAPPED: assert property (REG_REQ_I.rd && req_hit |=>
		REG_RVALID_O && REG_RDATA_O == $past(reg_q[req_idx]))
		else $error("mapped read returned a wrong value");

	// Read data stands until the next read; valid never comes unasked
	AST_RDATA_HOLD: assert property (!REG_REQ_I.rd |=> $stable(REG_RDATA_O))
		else $error("read data changed without a read");

	AST_RVALID_IDLE: assert property (!REG_REQ_I.rd |=> !REG_RVALID_O)
		else $error("read valid without a read");

	// ================================================================
	// Checks on the range ends

	// Top current code gives the range maximum, and one fifth of it when reduced
	AST_FAST_TOP: assert property (reg_q[0][7:2] == 6'h3F |=>
		CFG_O.fast_charge_ma == 13'h11C0)
		else $error("top fast-charge code not at range maximum");

	AST_REDUCED_TOP: assert property (reg_q[0][7:2] == 6'h3F && reg_q[0][0] |=>
		CFG_O.applied_charge_ma == 13'h038C)
		else $error("reduced current at top code wrong");

	AST_PRE_TOP: assert property (reg_q[1][7:4] == 4'hF |=>
		CFG_O.precharge_ma == 13'h0800)
		else $error("top precharge code not at range maximum");

	AST_TERM_TOP: assert property (reg_q[1][3:0] == 4'hF |=>
		CFG_O.termination_ma == 13'h0800)
		else $error("top termination code not at range maximum");

	// The last valid voltage code; the next one up is flagged, not clamped
	AST_VOLT_TOP: assert property (reg_q[2][7:2] == 6'h38 |=>
		CFG_O.charge_voltage_mv == 13'h1130 && CFG_O.voltage_code_valid)
		else $error("top voltage code wrong");

	AST_VOLT_OVER: assert property (reg_q[2][7:2] == 6'h39 |=>
		!CFG_O.voltage_code_valid)
		else $error("voltage code above the top not flagged");
endmodule

// File: bench/ccr_host.sv
module ccr_host (
	// Clock
	input  wire logic          clk_i,
	// Read answer from the register port
	input  wire logic [7:0]    rdata_i,
	input  wire logic          rvalid_i,
	// Request towards the register port
	output ccr_pkg::ccr_req_t  req_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import ccr_pkg::*;

	// ================================================================
	// Idle bus at time zero
	initial begin
		req_o = '0;
	end

	// One request for one cycle; caller enters just after an edge
	task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w,
		input logic r, output logic [7:0] q, output logic v);
		logic [7:0] wd;
		wd = (w && a == CCR_FCC_ADDR) ? (d & 8'hFD) : d;
		req_o = '{addr: a, wdata: wd, wr: w, rd: r};
		@(posedge clk_i);
		#1;
		q = rdata_i;
		v = rvalid_i;
	endtask

	// Released bus shows the inverse, so stale values cannot pass for data
	task automatic idle();
		req_o = '{addr: ~req_o.addr, wdata: ~req_o.wdata, wr: 1'b0, rd: 1'b0};
	endtask
endmodule

// File: bench/test_charger_config_regs_2_to_5.sv
module test_charger_config_regs_2_to_5;
	timeunit 1ns;
	timeprecision 100ps;
	import ccr_pkg::*;

	// ================================================================
	// Signals and model state
	logic       clk_sys;
	logic       rst_n;
	ccr_req_t   req;
	logic [7:0] rdata;
	logic       rvalid;
	ccr_cfg_t   cfg;
	int         bad_count = 0;
	int         n_tests   = 0;
	int         mdl [2:5];
	int         wdog [4]  = '{0, 40, 80, 160};
	int         tlim [4]  = '{5, 8, 12, 20};
	logic [7:0] dir_a [6] = '{8'h04, 8'h04, 8'h02, 8'h02, 8'h03, 8'h03};
	logic [7:0] dir_d [6] = '{8'hE0, 8'hE7, 8'hFD, 8'h00, 8'hF0, 8'h0F};

	// ================================================================
	// Clock, design and host
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	ccr_top i_ccr_top (
		.CLK_SYS_I    (clk_sys),
		.RST_N_I      (rst_n),
		.REG_REQ_I    (req),
		.REG_RDATA_O  (rdata),
		.REG_RVALID_O (rvalid),
		.CFG_O        (cfg)
	);

	ccr_host i_ccr_host (
		.clk_i    (clk_sys),
		.rdata_i  (rdata),
		.rvalid_i (rvalid),
		.req_o    (req)
	);

	// ================================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Reset, then wait past the two-flop release before any request
	task automatic do_reset();
		@(posedge clk_sys);
		#1 rst_n = 1'b0;
		repeat (5) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		mdl = '{8'h60, 8'h11, 8'hB2, 8'h9A};
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       v;
		i_ccr_host.xfer(a, d, 1'b1, 1'b0, q, v);
		check(16'(v), 16'h0000, "rvalid after write");
		if (a >= 2 && a <= 5) begin
			mdl[a] = (a == 2) ? (d & 8'hFD) : d;
		end
	endtask

	task automatic rd(input logic [7:0] a);
		logic [7:0] q;
		logic       v;
		int         e;
		e = (a >= 2 && a <= 5) ? mdl[a] : 0;
		i_ccr_host.xfer(a, 8'h00, 1'b0, 1'b1, q, v);
		check(16'(v), 16'h0001, "rvalid");
		check(16'(q), 16'(e), "rdata");
	endtask

	// Decoded settings worked out from the model registers
	task automatic check_cfg();
		int fc;
		int r2;
		int r3;
		int r4;
		int r5;
		r2 = mdl[2];
		r3 = mdl[3];
		r4 = mdl[4];
		r5 = mdl[5];
		fc = 512 + 64 * (r2 >> 2);
		check(16'(cfg.fast_charge_ma), 16'(fc), "fast");
		check(16'(cfg.applied_charge_ma), 16'((r2 & 1) ? fc / 5 : fc), "applied");
		check(16'(cfg.precharge_ma), 16'(128 + 128 * (r3 >> 4)), "pre");
		check(16'(cfg.termination_ma), 16'(128 + 128 * (r3 & 15)), "term");
		check(16'(cfg.charge_voltage_mv), 16'(3504 + 16 * (r4 >> 2)), "volt");
		check(16'(cfg.voltage_code_valid), 16'((r4 >> 2) <= 56), "valid");
		check(16'(cfg.entry_threshold_mv), 16'((r4 & 2) ? 3000 : 2800), "entry");
		check(16'(cfg.recharge_offset_mv), 16'((r4 & 1) ? 300 : 100), "rechg");
		check(16'(cfg.term_enable), 16'((r5 >> 7) & 1), "term en");
		check(16'(cfg.term_indicator_early), 16'((r5 >> 6) & 1), "indicator");
		check(16'(cfg.watchdog_period_s), 16'(wdog[(r5 >> 4) & 3]), "wdog");
		check(16'(cfg.safety_timer_enable), 16'((r5 >> 3) & 1), "timer en");
		check(16'(cfg.time_limit_h), 16'(tlim[(r5 >> 1) & 3]), "limit");
		check(16'(cfg.cold_charge_ma), 16'((r5 & 1) ? fc / 5 : fc / 2), "cold");
	endtask

	// Write, read back in the very next cycle, then compare settings
	task automatic step(input logic [7:0] a, input logic [7:0] d);
		wr(a, d);
		rd(a);
		i_ccr_host.idle();
		@(posedge clk_sys);
		#1;
		check_cfg();
	endtask

	task automatic reset_reads();
		for (int a = 0; a < 8; a++) begin
			rd(8'(a));
		end
		i_ccr_host.idle();
		@(posedge clk_sys);
		#1;
		check_cfg();
	endtask

	// ================================================================
	// Bounded run time; a hang counts as a mismatch
	initial begin
		repeat (50000) @(posedge clk_sys);
		bad_count++;
		$display("[ERR] %0t run time limit reached", $time);
		give_verdict();
	end

	// ================================================================
	// Main sequence
	initial begin
		logic [7:0] q;
		logic       v;
		rst_n = 1'b0;
		void'($urandom(32'h85b98dfc));
		do_reset();
		reset_reads();
		$display("Test reset values done");
		// Every watchdog and time limit code, both enables and the cold bit toggled alongside
		for (int i = 0; i < 4; i++) begin
			step(8'h05, 8'((i << 4) | (i << 1) | ((i & 1) << 7) | ((i >> 1) << 3) | (i & 1)));
		end
		// Boundary codes: highest valid voltage, one above, extreme currents
		for (int i = 0; i < 6; i++) begin
			step(dir_a[i], dir_d[i]);
		end
		$display("Test field codes done");
		for (int i = 0; i < 40; i++) begin
			step(8'($urandom_range(0, 7)), 8'($urandom));
		end
		$display("Test random access done");
		// Same-cycle write and read returns the old value
		i_ccr_host.xfer(8'h04, 8'h5A, 1'b1, 1'b1, q, v);
		check(16'(q), 16'(mdl[4]), "old value");
		mdl[4] = 8'h5A;
		rd(8'h04);
		i_ccr_host.idle();
		$display("Test same cycle access done");
		// Second reset in mid-run restores every register
		do_reset();
		reset_reads();
		$display("Test second reset done");
		give_verdict();
	end
endmodule
